// File: nor_host_regs.svh
`ifndef NOR_HOST_REGS_SVH
`define NOR_HOST_REGS_SVH
// Timing figures in ns at 100 ns clock period
`define CLK_PERIOD_NS       100
`define RESET_PULSE_NS      500
`define RESET_REC_SEL_NS    200
`define RESET_REC_STB_NS    200
`define ACCESS_NS           100
`define STROBE_NS           100
// Least times round up to whole cycles
`define RESET_PULSE_CYC     ((`RESET_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REC_SEL_CYC         ((`RESET_REC_SEL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REC_STB_CYC         ((`RESET_REC_STB_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ACCESS_CYC          ((`ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_CYC          ((`STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define POLL_LANE_MASK      16'h00ff
`define LOW_LANE_MASK       16'h00ff
`endif

// File: nor_host_pkg.sv
package nor_host_pkg;
  typedef enum logic [6:0] {
    ST_RESET  = 7'h01,
    ST_RECOV  = 7'h02,
    ST_IDLE   = 7'h04,
    ST_RD     = 7'h08,
    ST_WR_LO  = 7'h10,
    ST_WR_HI  = 7'h20,
    ST_DONE   = 7'h40
  } host_state_type;
endpackage

// File: nor_pin_sync.sv
module nor_pin_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rstn_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end
  assign sync_o = sync_ff;
endmodule // nor_pin_sync

// File: nor_flash_pin_interface.sv
`include "nor_host_regs.svh"
module nor_flash_pin_interface #(
  parameter int ADDR_W      = 26,
  parameter int USED_ADDR_W = 23
) (
  input  wire logic                        ref_clk_i,
  input  wire logic                        rstn_i,
  input  wire logic                        req_i,
  input  wire logic                        req_write_i,
  input  wire logic                        req_poll_i,
  input  wire logic                        byte_mode_i,
  input  wire logic [ADDR_W-1:0]           req_addr_i,
  input  wire logic [15:0]                 req_wdata_i,
  output logic                             req_ready_o,
  output logic                             rsp_valid_o,
  output logic      [15:0]                 rsp_rdata_o,
  output logic                             dev_busy_o,
  output logic                             chip_sel_n_o,
  output logic                             out_en_n_o,
  output logic                             write_strobe_n_o,
  output logic                             dev_reset_n_o,
  output logic                             width_sel_o,
  output logic      [ADDR_W-1:0]           addr_o,
  input  wire logic [14:0]                 data_i,
  output logic      [14:0]                 data_o,
  output logic                             data_oe_o,
  input  wire logic                        data15_or_addr_lsb_i,
  output logic                             data15_or_addr_lsb_o,
  output logic                             data15_or_addr_lsb_oe_o,
  input  wire logic                        ready_busy_n_i
);
  import nor_host_pkg::*;

  localparam int CW = 8;
  localparam logic [CW-1:0] RST_CYC = CW'(`RESET_PULSE_CYC);
  localparam logic [CW-1:0] REC_CYC = CW'((`REC_SEL_CYC > `REC_STB_CYC) ?
                                          `REC_SEL_CYC : `REC_STB_CYC);
  localparam logic [CW-1:0] ACC_CYC = CW'(`ACCESS_CYC);
  localparam logic [CW-1:0] STB_CYC = CW'(`STROBE_CYC);

  host_state_type      state_ff, nxt_state;
  logic [CW-1:0]       cnt_ff, nxt_cnt;
  logic                ce_n_ff, nxt_ce_n;
  logic                oe_n_ff, nxt_oe_n;
  logic                we_n_ff, nxt_we_n;
  logic                rst_n_ff, nxt_rst_n;
  logic                wide_ff, nxt_wide;
  logic                poll_ff, nxt_poll;
  logic                drive_ff, nxt_drive;
  logic [ADDR_W-1:0]   addr_ff, nxt_addr;
  logic                lsb_ff, nxt_lsb;
  logic [15:0]         wdata_ff, nxt_wdata;
  logic [15:0]         rdata_ff, nxt_rdata;
  logic                valid_ff, nxt_valid;
  logic [15:0]         pins_sync;
  logic                rb_sync;
  logic [15:0]         rd_word;

  nor_pin_sync #(.W(17)) u_sync (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .async_i   ({ready_busy_n_i, data15_or_addr_lsb_i, data_i}),
    .sync_o    ({rb_sync, pins_sync})
  );

  // x8 keeps only the low lane; polling reads ignore 15..8 too
  always_comb
  begin
    rd_word = pins_sync;
    if (!wide_ff || poll_ff)
    begin
      rd_word = pins_sync & `LOW_LANE_MASK;
    end
    if (poll_ff)
    begin
      rd_word = pins_sync & `POLL_LANE_MASK;
    end
  end

  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_ce_n  = ce_n_ff;
    nxt_oe_n  = oe_n_ff;
    nxt_we_n  = we_n_ff;
    nxt_rst_n = rst_n_ff;
    nxt_wide  = wide_ff;
    nxt_poll  = poll_ff;
    nxt_drive = drive_ff;
    nxt_addr  = addr_ff;
    nxt_lsb   = lsb_ff;
    nxt_wdata = wdata_ff;
    nxt_rdata = rdata_ff;
    nxt_valid = 1'b0;
    case (state_ff)
      ST_RESET:
      begin
        // Reset pin low for the full minimum pulse
        if (cnt_ff >= RST_CYC - CW'(1))
        begin
          nxt_rst_n = 1'b1;
          nxt_cnt   = '0;
          nxt_state = ST_RECOV;
        end
        else
        begin
          nxt_cnt = cnt_ff + CW'(1);
        end
      end
      ST_RECOV:
      begin
        // Later of the two recovery times
        if (cnt_ff >= REC_CYC - CW'(1))
        begin
          nxt_state = ST_IDLE;
        end
        else
        begin
          nxt_cnt = cnt_ff + CW'(1);
        end
      end
      ST_IDLE:
      begin
        if (req_i)
        begin
          // Width latched per access so it never moves mid-write
          nxt_wide  = byte_mode_i ? 1'b0 : 1'b1;
          nxt_poll  = req_poll_i;
          // Bits above the part's density are held low; a byte address has one more
          nxt_addr  = byte_mode_i ? (req_addr_i & ADDR_W'((1 << (USED_ADDR_W + 1)) - 1))
                                  : (req_addr_i & ADDR_W'((1 << USED_ADDR_W) - 1));
          nxt_lsb   = req_addr_i[0];
          nxt_wdata = req_wdata_i;
          nxt_cnt   = '0;
          nxt_ce_n  = 1'b0;
          if (req_write_i)
          begin
            nxt_oe_n  = 1'b1;
            nxt_we_n  = 1'b0;
            nxt_drive = 1'b1;
            nxt_state = ST_WR_LO;
          end
          else
          begin
            nxt_oe_n  = 1'b0;
            nxt_state = ST_RD;
          end
        end
      end
      ST_RD:
      begin
        if (cnt_ff >= ACC_CYC + CW'(2))
        begin
          nxt_rdata = rd_word;
          nxt_valid = 1'b1;
          nxt_oe_n  = 1'b1;
          nxt_ce_n  = 1'b1;
          nxt_state = ST_DONE;
        end
        else
        begin
          nxt_cnt = cnt_ff + CW'(1);
        end
      end
      ST_WR_LO:
      begin
        // Strobe kept wide; 3ns glitch filter never matters at this rate
        if (cnt_ff >= STB_CYC - CW'(1))
        begin
          nxt_we_n  = 1'b1;
          nxt_state = ST_WR_HI;
        end
        else
        begin
          nxt_cnt = cnt_ff + CW'(1);
        end
      end
      ST_WR_HI:
      begin
        // Data held one cycle past the rising strobe
        nxt_drive = 1'b0;
        nxt_ce_n  = 1'b1;
        nxt_valid = 1'b1;
        nxt_state = ST_DONE;
      end
      ST_DONE:
      begin
        nxt_state = ST_IDLE;
      end
      default:
      begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state_ff <= ST_RESET;
      cnt_ff   <= '0;
      ce_n_ff  <= 1'b1;
      oe_n_ff  <= 1'b1;
      we_n_ff  <= 1'b1;
      rst_n_ff <= 1'b0;
      wide_ff  <= 1'b1;
      poll_ff  <= 1'b0;
      drive_ff <= 1'b0;
      addr_ff  <= '0;
      lsb_ff   <= 1'b0;
      wdata_ff <= '0;
      rdata_ff <= '0;
      valid_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      ce_n_ff  <= nxt_ce_n;
      oe_n_ff  <= nxt_oe_n;
      we_n_ff  <= nxt_we_n;
      rst_n_ff <= nxt_rst_n;
      wide_ff  <= nxt_wide;
      poll_ff  <= nxt_poll;
      drive_ff <= nxt_drive;
      addr_ff  <= nxt_addr;
      lsb_ff   <= nxt_lsb;
      wdata_ff <= nxt_wdata;
      rdata_ff <= nxt_rdata;
      valid_ff <= nxt_valid;
    end
  end

  assign req_ready_o      = (state_ff == ST_IDLE);
  assign rsp_valid_o      = valid_ff;
  assign rsp_rdata_o      = rdata_ff;
  // Low on the shared pulled-up line means some device busy
  assign dev_busy_o       = ~rb_sync;
  assign chip_sel_n_o     = ce_n_ff;
  assign out_en_n_o       = oe_n_ff;
  assign write_strobe_n_o = we_n_ff;
  assign dev_reset_n_o    = rst_n_ff;
  assign width_sel_o      = wide_ff;
  assign addr_o           = wide_ff ? addr_ff : (addr_ff >> 1);
  assign data_o           = wide_ff ? wdata_ff[14:0] : {7'h00, wdata_ff[7:0]};
  assign data_oe_o        = drive_ff;
  // Top pin: data bit 15 in x16, address lsb driven always in x8
  assign data15_or_addr_lsb_o    = wide_ff ? wdata_ff[15] : lsb_ff;
  assign data15_or_addr_lsb_oe_o = wide_ff ? drive_ff : 1'b1;

  a_read_oe_ce: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    !oe_n_ff |-> !ce_n_ff && we_n_ff && !drive_ff)
    else $error("read enable without select or with strobe");
  a_write_oe_high: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    !we_n_ff |-> oe_n_ff && drive_ff)
    else $error("write strobe with output enable low");
  a_reset_pulse: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    $rose(rst_n_ff) |-> state_ff == ST_RECOV && $past(cnt_ff) == RST_CYC - CW'(1))
    else $error("reset pulse too short");
  a_recov_wait: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    $rose(rst_n_ff) |-> ce_n_ff [*2])
    else $error("access started during recovery");
  a_width_steady: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (state_ff == ST_WR_LO) |=> $stable(wide_ff))
    else $error("width moved during write");
  a_strobe_data: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    $rose(we_n_ff) |-> drive_ff && !ce_n_ff)
    else $error("data dropped at strobe rise");
  a_poll_mask: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    valid_ff && poll_ff |-> rdata_ff[14:8] == 7'h00)
    else $error("upper lanes kept in poll read");
  a_lsb_x8: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    !wide_ff |-> data15_or_addr_lsb_oe_o && data15_or_addr_lsb_o == lsb_ff)
    else $error("x8 address lsb not driven");
endmodule // nor_flash_pin_interface

// File: nor_flash_model.sv
module nor_flash_model (
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic        rst_n_i,
  input  wire logic        width_i,
  input  wire logic [25:0] addr_i,
  input  wire logic [15:0] dq_i,
  output logic      [15:0] dq_o,
  output logic      [15:0] dq_oe_o,
  output logic             busy_pull_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [25:0] cmd_addr;
  logic [7:0]  cmd_data;
  logic        host_err;
  logic        width_at_fall;
  logic [26:0] rd_idx;
  logic [7:0]  w8;
  time         t_rst_lo;
  time         t_rst_hi;
  time         t_we_lo;
  initial
  begin
    t_we_lo = 0;
    busy_pull_o = 1'b0;
    host_err = 1'b0;
    cmd_addr = '0;
    cmd_data = '0;
    t_rst_lo = 0;
    t_rst_hi = 0;
  end
  always @(negedge rst_n_i)
  begin
    t_rst_lo = $time;
    busy_pull_o = 1'b0;
  end
  always @(posedge rst_n_i)
  begin
    if ($time - t_rst_lo < 500) host_err = 1'b1;
    t_rst_hi = $time;
  end
  always @(negedge ce_n_i or negedge we_n_i)
    if (rst_n_i && ($time - t_rst_hi < 200)) host_err = 1'b1;
  always @(negedge oe_n_i)
    if (!we_n_i) host_err = 1'b1;
  always @(negedge we_n_i)
  begin
    t_we_lo = $time;
    // Address, width and select move in the same step as the strobe
    #1;
    if (!ce_n_i)
    begin
      cmd_addr = width_i ? addr_i : {addr_i[24:0], dq_i[15]};
      width_at_fall = width_i;
      if (!oe_n_i) host_err = 1'b1;
    end
  end
  // Upper lanes ignored on writes; program time is a plain guess
  // Strobe pulses under 3ns are glitches and latch no data
  always @(posedge we_n_i)
    if (!ce_n_i && rst_n_i && ($time - t_we_lo >= 3))
    begin
      cmd_data = dq_i[7:0];
      if (width_i != width_at_fall) host_err = 1'b1;
      busy_pull_o = 1'b1;
      busy_pull_o <= #800 1'b0;
    end
  // Small part: only low address bits decoded
  always @*
  begin
    rd_idx = width_i ? {1'b0, addr_i} : {addr_i, dq_i[15]};
    w8 = width_i ? rd_idx[7:0] : rd_idx[8:1];
    dq_o = width_i ? {~w8, w8} : {8'h00, rd_idx[0] ? ~w8 : w8};
    dq_oe_o = 16'h0000;
    if (!ce_n_i && !oe_n_i && we_n_i && rst_n_i)
      dq_oe_o = width_i ? 16'hffff : 16'h00ff;
  end
endmodule // nor_flash_model

// File: test_nor_flash_pin_interface.sv
`define CHECK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin failures++; \
  $display("ERROR %0t: mismatch got %h expected %h", $time, got, exp); end end
module test_nor_flash_pin_interface;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rstn, req, req_wr, req_poll, byte_mode, ready, rsp_valid, dev_busy;
  logic        ce_n, oe_n, we_n, dev_rst_n, width, data_oe, top_o, top_oe, flt, m_busy;
  logic [25:0] req_addr, addr;
  logic [15:0] wdata, rdata, bus, m_dq, m_oe, drv, den;
  logic [14:0] data_o;
  int          failures, samples_checked;
  assign drv = {top_o, data_o};
  assign den = {top_oe, {15{data_oe}}};
  // Undriven lines toggle so a stale value cannot pass
  assign bus = (den & drv) | (~den & m_oe & m_dq) | (~den & ~m_oe & {16{flt}});
  nor_flash_pin_interface i_nor_flash_pin_interface (.ref_clk_i(clk), .rstn_i(rstn),
    .req_i(req), .req_write_i(req_wr), .req_poll_i(req_poll), .byte_mode_i(byte_mode),
    .req_addr_i(req_addr), .req_wdata_i(wdata), .req_ready_o(ready), .rsp_valid_o(rsp_valid),
    .rsp_rdata_o(rdata), .dev_busy_o(dev_busy), .chip_sel_n_o(ce_n), .out_en_n_o(oe_n),
    .write_strobe_n_o(we_n), .dev_reset_n_o(dev_rst_n), .width_sel_o(width), .addr_o(addr),
    .data_i(bus[14:0]), .data_o(data_o), .data_oe_o(data_oe), .data15_or_addr_lsb_i(bus[15]),
    .data15_or_addr_lsb_o(top_o), .data15_or_addr_lsb_oe_o(top_oe),
    .ready_busy_n_i(!m_busy));
  nor_flash_model i_nor_flash_model (.ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n),
    .rst_n_i(dev_rst_n), .width_i(width), .addr_i(addr), .dq_i(bus), .dq_o(m_dq),
    .dq_oe_o(m_oe), .busy_pull_o(m_busy));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) flt <= (flt === 1'b1) ? 1'b0 : 1'b1;
  task automatic final_report();
    if (failures == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic do_reset();
    int n;
    @(negedge clk) rstn = 1'b0;
    repeat (8) @(negedge clk);
    `CHECK({ce_n, oe_n, we_n, dev_rst_n, ready}, 5'b11100)
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    `CHECK(dev_rst_n, 1'b0)
    for (n = 0; n < 30 && ready !== 1'b1; n++) @(negedge clk);
    `CHECK(ready, 1'b1)
  endtask
  task automatic xfer(input logic wr, input logic poll, input logic x8, input logic [25:0] a,
                      input logic [15:0] wd, input int exp_lat, input logic [25:0] exp_pa);
    int n;
    int lat;
    @(negedge clk);
    {req, req_wr, req_poll, byte_mode, req_addr, wdata} = {1'b1, wr, poll, x8, a, wd};
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (ready === 1'b1) break;
    end
    @(negedge clk) req = 1'b0;
    `CHECK({addr, width, ce_n, oe_n, we_n}, {exp_pa, !x8, 1'b0, wr, !wr})
    for (lat = 1; lat < 20 && rsp_valid !== 1'b1; lat++) @(negedge clk);
    `CHECK(lat, exp_lat)
  endtask
  task automatic t_read16();
    xfer(1'b0, 1'b0, 1'b0, 26'h1000005, 16'h0000, 5, 26'h0000005);
    `CHECK(rdata, 16'hfa05)
  endtask
  task automatic t_read8();
    xfer(1'b0, 1'b0, 1'b1, 26'h180000b, 16'h0000, 5, 26'h0400005);
    `CHECK(rdata, 16'h00fa)
  endtask
  task automatic t_poll();
    xfer(1'b0, 1'b1, 1'b0, 26'h0000003, 16'h0000, 5, 26'h0000003);
    `CHECK(rdata, 16'h0003)
  endtask
  task automatic wait_idle_busy();
    int n;
    repeat (4) @(negedge clk);
    `CHECK(dev_busy, 1'b1)
    for (n = 0; n < 20 && dev_busy !== 1'b0; n++) @(negedge clk);
    `CHECK(dev_busy, 1'b0)
  endtask
  task automatic t_write16();
    xfer(1'b1, 1'b0, 1'b0, 26'h0000555, 16'h12aa, 3, 26'h0000555);
    `CHECK({i_nor_flash_model.cmd_addr, i_nor_flash_model.cmd_data}, {26'h555, 8'haa})
    wait_idle_busy();
  endtask
  task automatic t_write8_then_read();
    xfer(1'b1, 1'b0, 1'b1, 26'h00002ab, 16'hff55, 3, 26'h0000155);
    `CHECK({i_nor_flash_model.cmd_addr, i_nor_flash_model.cmd_data}, {26'h2ab, 8'h55})
    wait_idle_busy();
    t_read16();
  endtask
  initial
  begin
    {rstn, req, req_wr, req_poll, byte_mode, req_addr, wdata} = '0;
    failures = 0;
    samples_checked = 0;
    do_reset();
    t_read16();
    t_read8();
    t_poll();
    t_write16();
    t_write8_then_read();
    do_reset();
    t_read8();
    `CHECK(i_nor_flash_model.host_err, 1'b0)
    final_report();
  end
  initial
  begin
    #1000000;
    failures++;
    final_report();
  end
endmodule // test_nor_flash_pin_interface
